// ===== hdl/tpi_cfg.svh
// Purpose: shared constants for both ends of the touch panel serial port
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes: host register offsets are byte addresses on the AHB-Lite bus
// Operation
// - slave answers 7-bit address, default 0x5d
// - two address pairs, picked at power-on
// - host picks pair via reset and interrupt
// - standard 100 kHz and fast 400 kHz rates
// - master alone begins transfers with start
// - master ends every transfer with stop
// - matched address byte gets low ninth-clock acknowledge
// - mismatch: no acknowledge, idle until start
// - nine clocks per byte, msb first, ack
// - write: address, pointer high, low, data
// - pointer advances after every written data byte
// - read first sets pointer with write sequence
// - then restart, read address, clock data in; the host sends a stop and then a fresh start instead
// - sequential read returns successive registers
// - master acks all but last, then stop
// - command register byte selects panel action
`ifndef TPI_CFG_SVH
`define TPI_CFG_SVH

// ************************************************************
// link addresses
// ************************************************************
`define TPI_ADDR7 7'h5d
`define TPI_PAIR_A_WR {`TPI_ADDR7, 1'b0}
`define TPI_PAIR_A_RD {`TPI_ADDR7, 1'b1}
`define TPI_PAIR_B_WR 8'h28
`define TPI_PAIR_B_RD 8'h29

// ************************************************************
// device register space
// ************************************************************
`define TPI_REG_CMD 16'h8040
`define TPI_REG_LIGHT 16'h8041
`define TPI_REG_PROX 16'h8042
`define TPI_WIN_HI 12'h804
`define TPI_WO_LAST 4'h2
`define TPI_LIGHT_IDX 1
`define TPI_PROX_IDX 2

// ************************************************************
// timing
// ************************************************************
`define TPI_CLK_HZ 250000000
`define TPI_STD_HZ 100000
`define TPI_FAST_HZ 400000
`define TPI_QTR_STD ((`TPI_CLK_HZ + 4 * `TPI_STD_HZ - 1) / (4 * `TPI_STD_HZ))
`define TPI_QTR_FAST ((`TPI_CLK_HZ + 4 * `TPI_FAST_HZ - 1) / (4 * `TPI_FAST_HZ))
`define TPI_RST_HOLD_US 100
`define TPI_RST_HOLD_CYC (`TPI_RST_HOLD_US * (`TPI_CLK_HZ / 1000000))
`define TPI_INT_LEAD_US 1
`define TPI_INT_LEAD_CYC (`TPI_INT_LEAD_US * (`TPI_CLK_HZ / 1000000))

// ************************************************************
// host registers and fields
// ************************************************************
`define TPI_HR_CTRL 8'h00
`define TPI_HR_REGADDR 8'h04
`define TPI_HR_LEN 8'h08
`define TPI_HR_WDATA 8'h0c
`define TPI_HR_RDATA 8'h10
`define TPI_HR_STATUS 8'h14
`define TPI_CTRL_GO 0
`define TPI_CTRL_RD 1
`define TPI_CTRL_FAST 2
`define TPI_CTRL_INIT 8
`define TPI_CTRL_PAIR 9
`define TPI_CTRL_LEAD 10
`define TPI_ST_BUSY 0
`define TPI_ST_NACK 1
`define TPI_ST_READY 2

`endif

// ===== hdl/tpi_pkg.sv
// Purpose: types shared by both ends of the touch panel serial port
// Assumes: nothing
// Notes: command codes follow the command register encoding
package tpi_pkg;
	typedef enum logic [7:0] {
		TPI_CMD_COORD = 8'h00,
		TPI_CMD_DIFF = 8'h01,
		TPI_CMD_SOFT_RESET = 8'h02,
		TPI_CMD_BASE_UPDATE = 8'h03,
		TPI_CMD_BASE_CAL = 8'h04,
		TPI_CMD_SCREEN_OFF = 8'h05
	} tpi_cmd_type;
endpackage : tpi_pkg

// ===== hdl/tpi_link_if.sv
// Purpose: two-wire link plus reset and interrupt pins between host and panel
// Assumes: pull-ups on clock, data and interrupt lines
// Notes: open-drain lines are resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface tpi_link_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic h_int_o;
	logic h_int_oe;
	logic rst_n;
	logic scl;
	logic sda;
	logic intl;
	assign scl = !(h_scl_oe && !h_scl_o);
	assign sda = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);
	assign intl = h_int_oe ? h_int_o : 1'b1;
	modport host (
		output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, h_int_o, h_int_oe, rst_n,
		input scl, sda
	);
	modport dev (
		output d_sda_o, d_sda_oe,
		input scl, sda, intl, rst_n
	);
endinterface : tpi_link_if
`default_nettype wire

// ===== hdl/tpi_dev.sv
// Purpose: panel end of the two-wire port with pointer and command area
// Assumes: nrst_i is tied to the link reset pin; link is synchronous to clk_i
// Notes: only the 16-byte window from the command register is stored
`include "tpi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tpi_dev
	import tpi_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// link
	tpi_link_if.dev link,
	// panel side
	output logic addr_pair_o,
	output logic cmd_stb_o,
	output logic [7:0] cmd_code_o,
	output logic diff_mode_o,
	output logic screen_off_o,
	output logic [7:0] key_light_o,
	output logic [7:0] prox_en_o
);

	typedef enum logic [2:0] {
		TD_IDLE,
		TD_RX,
		TD_RX_END,
		TD_ACK,
		TD_TX,
		TD_MACK,
		TD_MACK_END
	} tpi_dst_type;

	tpi_dst_type st_reg;
	logic scl_reg;
	logic sda_reg;
	logic strap_done_reg;
	logic pair_reg;
	logic [2:0] bit_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic [1:0] phase_reg;
	logic rd_reg;
	logic ack_reg;
	logic oe_reg;
	logic [15:0] ptr_reg;
	logic [7:0] win_mem [16];
	logic cmd_stb_reg;
	logic [7:0] code_reg;
	logic diff_reg;
	logic scr_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rx_byte;
	logic rx_done;
	logic wr_stb;
	logic load_tx;
	logic match;
	logic win_hit;
	logic [3:0] idx;
	logic [7:0] rd_byte;
	logic soft_rst;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;

	// ************************************************************
	// line sampling and bus conditions
	// ************************************************************
	// 250 MHz sampling leaves many cycles per phase even at fast rate
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end
		else
		begin
			scl_reg <= link.scl;
			sda_reg <= link.sda;
		end
	end

	assign scl_rise = link.scl && !scl_reg;
	assign scl_fall = !link.scl && scl_reg;
	assign start_c = scl_reg && link.scl && sda_reg && !link.sda;
	assign stop_c = scl_reg && link.scl && !sda_reg && link.sda;

	// ************************************************************
	// address pair strap
	// ************************************************************
	// caught on the first edge after release, never under reset
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			strap_done_reg <= 1'b0;
			pair_reg <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			pair_reg <= link.intl;
		end
	end

	assign wr_addr = pair_reg ? `TPI_PAIR_B_WR : `TPI_PAIR_A_WR;
	assign rd_addr = pair_reg ? `TPI_PAIR_B_RD : `TPI_PAIR_A_RD;

	// ************************************************************
	// byte engine
	// ************************************************************
	assign rx_byte = {sh_reg[6:0], link.sda};
	assign rx_done = (st_reg == TD_RX) && scl_rise && (bit_reg == 3'h7);
	assign wr_stb = rx_done && (phase_reg == 2'h3);
	assign match = (rx_byte == wr_addr) || (rx_byte == rd_addr);
	assign load_tx = scl_fall && (((st_reg == TD_ACK) && rd_reg) || (st_reg == TD_MACK_END));

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= TD_IDLE;
			bit_reg <= 3'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			phase_reg <= 2'h0;
			rd_reg <= 1'b0;
			ack_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else if (start_c)
		begin
			st_reg <= TD_RX;
			bit_reg <= 3'h0;
			phase_reg <= 2'h0;
			oe_reg <= 1'b0;
		end
		else if (stop_c)
		begin
			st_reg <= TD_IDLE;
			oe_reg <= 1'b0;
		end
		else if (load_tx)
		begin
			tx_reg <= rd_byte;
			oe_reg <= !rd_byte[7];
			bit_reg <= 3'h0;
			st_reg <= TD_TX;
		end
		else
		begin
			case (st_reg)
				TD_RX:
					if (scl_rise)
					begin
						sh_reg <= rx_byte; // msb arrives first
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7)
						begin
							st_reg <= TD_RX_END;
							if (phase_reg == 2'h0)
							begin
								ack_reg <= match;
								rd_reg <= match && rx_byte[0];
								phase_reg <= 2'h1;
							end
							else
							begin
								ack_reg <= 1'b1;
								if (phase_reg != 2'h3)
									phase_reg <= phase_reg + 2'h1;
							end
						end
					end
				TD_RX_END:
					if (scl_fall)
					begin
						oe_reg <= ack_reg;
						st_reg <= ack_reg ? TD_ACK : TD_IDLE;
					end
				TD_ACK:
					if (scl_fall)
					begin
						oe_reg <= 1'b0; // ninth clock over
						bit_reg <= 3'h0;
						st_reg <= TD_RX;
					end
				TD_TX:
					if (scl_fall)
					begin
						if (bit_reg == 3'h7)
						begin
							oe_reg <= 1'b0;
							st_reg <= TD_MACK;
						end
						else
						begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							oe_reg <= !tx_reg[6];
							bit_reg <= bit_reg + 3'h1;
						end
					end
				TD_MACK:
					if (scl_rise)
						st_reg <= link.sda ? TD_IDLE : TD_MACK_END;
				default:
					;
			endcase
		end
	end

	assign link.d_sda_o = 1'b0;
	assign link.d_sda_oe = oe_reg;

	// ************************************************************
	// register pointer
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			ptr_reg <= 16'h0000;
		else if (rx_done && (phase_reg == 2'h1))
			ptr_reg <= {rx_byte, ptr_reg[7:0]};
		else if (rx_done && (phase_reg == 2'h2))
			ptr_reg <= {ptr_reg[15:8], rx_byte};
		else if (wr_stb || load_tx)
			ptr_reg <= ptr_reg + 16'h0001;
	end

	// ************************************************************
	// register window
	// ************************************************************
	// only a small window is kept; elsewhere writes drop and reads give zero
	assign win_hit = ptr_reg[15:4] == `TPI_WIN_HI;
	assign idx = ptr_reg[3:0];
	assign rd_byte = (win_hit && (idx > `TPI_WO_LAST)) ? win_mem[idx] : 8'h00;
	assign soft_rst = cmd_stb_reg && (code_reg == TPI_CMD_SOFT_RESET);

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i || soft_rst)
		begin
			for (int i = 0; i < 16; i++)
				win_mem[i] <= 8'h00;
		end
		else if (wr_stb && win_hit)
			win_mem[idx] <= rx_byte;
	end

	// ************************************************************
	// command register actions
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			cmd_stb_reg <= 1'b0;
			code_reg <= 8'h00;
			diff_reg <= 1'b0;
			scr_reg <= 1'b0;
		end
		else
		begin
			cmd_stb_reg <= wr_stb && (ptr_reg == `TPI_REG_CMD);
			if (wr_stb && (ptr_reg == `TPI_REG_CMD))
				code_reg <= rx_byte;
			if (cmd_stb_reg)
			begin
				case (code_reg)
					TPI_CMD_COORD:
						diff_reg <= 1'b0;
					TPI_CMD_DIFF:
						diff_reg <= 1'b1;
					TPI_CMD_SOFT_RESET:
					begin
						diff_reg <= 1'b0;
						scr_reg <= 1'b0;
					end
					TPI_CMD_SCREEN_OFF:
						scr_reg <= 1'b1;
					default:
						;
				endcase
			end
		end
	end

	// baseline codes surface only as the strobe with its code
	assign cmd_stb_o = cmd_stb_reg;
	assign cmd_code_o = code_reg;
	assign diff_mode_o = diff_reg;
	assign screen_off_o = scr_reg;
	assign key_light_o = win_mem[`TPI_LIGHT_IDX];
	assign prox_en_o = win_mem[`TPI_PROX_IDX];
	assign addr_pair_o = pair_reg;

endmodule : tpi_dev
`default_nettype wire

// ===== hdl/tpi_host.sv
// Purpose: host end: AHB-Lite registers driving a two-wire master and panel init
// Assumes: zero-wait slave, single word transfers
// Notes: up to four data bytes per transfer
`include "tpi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tpi_host
	import tpi_pkg::*;
#(
	parameter int unsigned RST_HOLD_CYC = `TPI_RST_HOLD_CYC
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// link
	tpi_link_if.host link
);

	typedef enum logic [2:0] {TH_IDLE, TH_RST, TH_POST, TH_START, TH_BIT, TH_STOP} tpi_hst_type;
	typedef enum logic [2:0] {HP_AW, HP_RH, HP_RL, HP_WD, HP_AR, HP_RD} tpi_hph_type;

	tpi_hst_type st_reg;
	tpi_hph_type ph_reg;
	logic ap_valid_reg;
	logic ap_wr_reg;
	logic [7:0] ap_addr_reg;
	logic rd_mode_reg;
	logic fast_reg;
	logic pair_reg;
	logic lead_reg;
	logic go_reg;
	logic init_go_reg;
	logic [15:0] regaddr_reg;
	logic [1:0] len_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic nack_reg;
	logic ready_reg;
	logic [9:0] qcnt_reg;
	logic [1:0] q_reg;
	logic [3:0] bit_reg;
	logic [1:0] cnt_reg;
	logic [7:0] tx_reg;
	logic [7:0] rxsh_reg;
	logic ackbit_reg;
	logic scl_low_reg;
	logic sda_low_reg;
	logic rst_n_reg;
	logic int_drv_reg;
	logic [15:0] tcnt_reg;
	logic tick;
	logic wr_c;
	logic rx_dir;
	logic last;

	// ************************************************************
	// bus slave
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ap_valid_reg <= 1'b0;
			ap_wr_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
		end
		else if (hready_i)
		begin
			ap_valid_reg <= hsel_i && htrans_i[1];
			ap_wr_reg <= hwrite_i;
			ap_addr_reg <= haddr_i[7:0];
		end
	end

	assign wr_c = ap_valid_reg && ap_wr_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			rd_mode_reg <= 1'b0;
			fast_reg <= 1'b0;
			pair_reg <= 1'b0;
			lead_reg <= 1'b0;
			go_reg <= 1'b0;
			init_go_reg <= 1'b0;
			regaddr_reg <= 16'h0000;
			len_reg <= 2'h0;
			wdata_reg <= 32'h00000000;
		end
		else
		begin
			go_reg <= 1'b0;
			init_go_reg <= 1'b0;
			if (wr_c && (ap_addr_reg == `TPI_HR_CTRL))
			begin
				go_reg <= hwdata_i[`TPI_CTRL_GO];
				rd_mode_reg <= hwdata_i[`TPI_CTRL_RD];
				fast_reg <= hwdata_i[`TPI_CTRL_FAST];
				init_go_reg <= hwdata_i[`TPI_CTRL_INIT];
				pair_reg <= hwdata_i[`TPI_CTRL_PAIR];
				lead_reg <= hwdata_i[`TPI_CTRL_LEAD];
			end
			else if (wr_c && (ap_addr_reg == `TPI_HR_REGADDR))
				regaddr_reg <= hwdata_i[15:0];
			else if (wr_c && (ap_addr_reg == `TPI_HR_LEN))
				len_reg <= hwdata_i[1:0];
			else if (wr_c && (ap_addr_reg == `TPI_HR_WDATA))
				wdata_reg <= hwdata_i;
		end
	end

	always_comb
	begin
		hrdata_o = 32'h00000000;
		if (ap_addr_reg == `TPI_HR_CTRL)
		begin
			hrdata_o[`TPI_CTRL_RD] = rd_mode_reg;
			hrdata_o[`TPI_CTRL_FAST] = fast_reg;
			hrdata_o[`TPI_CTRL_PAIR] = pair_reg;
			hrdata_o[`TPI_CTRL_LEAD] = lead_reg;
		end
		else if (ap_addr_reg == `TPI_HR_REGADDR)
			hrdata_o[15:0] = regaddr_reg;
		else if (ap_addr_reg == `TPI_HR_LEN)
			hrdata_o[1:0] = len_reg;
		else if (ap_addr_reg == `TPI_HR_WDATA)
			hrdata_o = wdata_reg;
		else if (ap_addr_reg == `TPI_HR_RDATA)
			hrdata_o = rdata_reg;
		else if (ap_addr_reg == `TPI_HR_STATUS)
		begin
			hrdata_o[`TPI_ST_BUSY] = st_reg != TH_IDLE;
			hrdata_o[`TPI_ST_NACK] = nack_reg;
			hrdata_o[`TPI_ST_READY] = ready_reg;
		end
	end

	// ************************************************************
	// quarter-bit tick
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i || (st_reg == TH_IDLE) || tick)
			qcnt_reg <= fast_reg ? 10'(`TPI_QTR_FAST - 1) : 10'(`TPI_QTR_STD - 1);
		else
			qcnt_reg <= qcnt_reg - 10'h001;
	end

	assign tick = (qcnt_reg == 10'h000) && (st_reg != TH_IDLE);

	// ************************************************************
	// init and link engine
	// ************************************************************
	assign rx_dir = ph_reg == HP_RD;
	assign last = cnt_reg == len_reg;

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= TH_IDLE;
			ph_reg <= HP_AW;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			cnt_reg <= 2'h0;
			tx_reg <= 8'h00;
			rxsh_reg <= 8'h00;
			ackbit_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			rst_n_reg <= 1'b0;
			int_drv_reg <= 1'b0;
			tcnt_reg <= 16'h0000;
			nack_reg <= 1'b0;
			ready_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			case (st_reg)
				TH_IDLE:
					if (init_go_reg)
					begin
						st_reg <= TH_RST;
						ready_reg <= 1'b0;
						rst_n_reg <= 1'b0;
						tcnt_reg <= 16'h0000;
						int_drv_reg <= lead_reg;
					end
					else if (go_reg && ready_reg)
					begin
						st_reg <= TH_START;
						ph_reg <= HP_AW;
						nack_reg <= 1'b0;
						rdata_reg <= 32'h00000000;
						q_reg <= 2'h0;
					end
				TH_RST:
				begin
					tcnt_reg <= tcnt_reg + 16'h0001;
					if (tcnt_reg == 16'(RST_HOLD_CYC - `TPI_INT_LEAD_CYC))
						int_drv_reg <= 1'b1; // level set before release
					if (tcnt_reg == 16'(RST_HOLD_CYC))
					begin
						rst_n_reg <= 1'b1;
						tcnt_reg <= 16'h0000;
						st_reg <= TH_POST;
					end
				end
				TH_POST:
				begin
					tcnt_reg <= tcnt_reg + 16'h0001;
					if (tcnt_reg == 16'(`TPI_INT_LEAD_CYC))
					begin
						int_drv_reg <= 1'b0;
						ready_reg <= 1'b1;
						st_reg <= TH_IDLE;
					end
				end
				TH_START:
					if (tick)
					begin
						q_reg <= q_reg + 2'h1;
						if (q_reg == 2'h0)
						begin
							sda_low_reg <= 1'b0;
							scl_low_reg <= 1'b0;
						end
						else if (q_reg == 2'h1)
							sda_low_reg <= 1'b1; // data falls, clock high
						else if (q_reg == 2'h2)
							scl_low_reg <= 1'b1;
						else
						begin
							bit_reg <= 4'h0;
							st_reg <= TH_BIT;
							if (ph_reg == HP_AR)
								tx_reg <= pair_reg ? `TPI_PAIR_B_RD : `TPI_PAIR_A_RD;
							else
								tx_reg <= pair_reg ? `TPI_PAIR_B_WR : `TPI_PAIR_A_WR;
						end
					end
				TH_BIT:
					if (tick)
					begin
						q_reg <= q_reg + 2'h1;
						if (q_reg == 2'h0)
						begin
							if (bit_reg != 4'h8)
								sda_low_reg <= !rx_dir && !tx_reg[7]; // msb first
							else
								sda_low_reg <= rx_dir && !last;
						end
						else if (q_reg == 2'h1)
							scl_low_reg <= 1'b0;
						else if (q_reg == 2'h2)
						begin
							if (bit_reg != 4'h8)
							begin
								rxsh_reg <= {rxsh_reg[6:0], link.sda};
								tx_reg <= {tx_reg[6:0], 1'b0};
							end
							else
								ackbit_reg <= link.sda;
						end
						else
						begin
							scl_low_reg <= 1'b1;
							bit_reg <= bit_reg + 4'h1;
							if (bit_reg == 4'h8)
							begin
								bit_reg <= 4'h0;
								if (!rx_dir && ackbit_reg)
								begin
									nack_reg <= 1'b1;
									st_reg <= TH_STOP;
								end
								else
								begin
									case (ph_reg)
										HP_AW:
										begin
											ph_reg <= HP_RH;
											tx_reg <= regaddr_reg[15:8];
										end
										HP_RH:
										begin
											ph_reg <= HP_RL;
											tx_reg <= regaddr_reg[7:0];
										end
										HP_RL:
										begin
											cnt_reg <= 2'h0;
											if (rd_mode_reg)
											begin
												ph_reg <= HP_AR;
												st_reg <= TH_STOP;
											end
											else
											begin
												ph_reg <= HP_WD;
												tx_reg <= wdata_reg[7:0];
											end
										end
										HP_WD:
											if (last)
												st_reg <= TH_STOP;
											else
											begin
												cnt_reg <= cnt_reg + 2'h1;
												tx_reg <= wdata_reg[{cnt_reg + 2'h1, 3'h0} +: 8];
											end
										HP_AR:
											ph_reg <= HP_RD;
										default:
										begin
											rdata_reg[{cnt_reg, 3'h0} +: 8] <= rxsh_reg;
											cnt_reg <= cnt_reg + 2'h1;
											if (last)
												st_reg <= TH_STOP;
										end
									endcase
								end
							end
						end
					end
				TH_STOP:
					if (tick)
					begin
						q_reg <= q_reg + 2'h1;
						if (q_reg == 2'h0)
							sda_low_reg <= 1'b1;
						else if (q_reg == 2'h1)
							scl_low_reg <= 1'b0;
						else if (q_reg == 2'h2)
							sda_low_reg <= 1'b0; // data rises, clock high
						else
							st_reg <= ((ph_reg == HP_AR) && !nack_reg) ? TH_START : TH_IDLE;
					end
				default:
					st_reg <= TH_IDLE;
			endcase
		end
	end

	assign link.h_scl_o = 1'b0;
	assign link.h_scl_oe = scl_low_reg;
	assign link.h_sda_o = 1'b0;
	assign link.h_sda_oe = sda_low_reg;
	assign link.h_int_o = pair_reg;
	assign link.h_int_oe = int_drv_reg;
	assign link.rst_n = rst_n_reg;

endmodule : tpi_host
`default_nettype wire

// ===== testbench/tpi_port_props.sv
// Purpose: link checks for the touch panel port
// Assumes: shared clock, fast rate at most
// Notes: sees interface signals only
`timescale 1ns/1ps
`default_nettype none
module tpi_port_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic h_scl_oe,
	input wire logic h_sda_oe,
	input wire logic d_sda_oe,
	input wire logic h_int_oe,
	input wire logic rst_n
);
	// ****
	// helpers
	// ****
	// 20 bits outlast the whole run, so no saturation
	logic [19:0] hi_cnt;
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			hi_cnt <= 20'h0;
		else
			hi_cnt <= scl ? hi_cnt + 20'h1 : 20'h0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	sequence s_release;
		$rose(rst_n);
	endsequence
	// ****
	// assertions
	// ****
	chk_start_by_host: assert property (s_start |-> h_sda_oe && !$past(d_sda_oe))
		else $error("start not made by host");
	chk_stop_by_host: assert property (s_stop |-> $past(h_sda_oe) && !h_sda_oe)
		else $error("stop not made by host");
	chk_dev_low_edge: assert property ($changed(d_sda_oe) && rst_n |-> !scl)
		else $error("device data moved with clock high");
	chk_int_at_release: assert property (s_release |-> h_int_oe)
		else $error("interrupt line not driven at release");
	chk_int_hold: assert property (s_release |=> h_int_oe [*8])
		else $error("interrupt line dropped too soon");
	chk_quiet_reset: assert property (!rst_n |-> !h_scl_oe && !d_sda_oe)
		else $error("link active while panel in reset");
	chk_high_time: assert property ($fell(scl) |-> hi_cnt >= 20'd300)
		else $error("clock high period too short");
	chk_ack_width: assert property ($rose(d_sda_oe) |=> d_sda_oe [*8])
		else $error("device drive too short");
endmodule : tpi_port_props
`default_nettype wire

// ===== testbench/tpi_port_test.sv
// Purpose: end to end bench for host and panel ends
// Assumes: fast link rate, shortened reset hold
// Notes: one slave, so hreadyout feeds hready
`timescale 1ns/1ps
`default_nettype none
module tpi_port_test
	import tpi_pkg::*;
;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic pair;
	logic diff;
	logic soff;
	logic [7:0] code;
	logic [7:0] light;
	logic [7:0] prox;
	logic stb;
	int stb_count = 0;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	tpi_link_if i_tpi_link_if ();
	tpi_host #(.RST_HOLD_CYC(300)) i_tpi_host (.clk_i(clk_i), .nrst_i(nrst_i),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .link(i_tpi_link_if));
	tpi_dev i_tpi_dev (.clk_i(clk_i), .nrst_i(i_tpi_link_if.rst_n), .link(i_tpi_link_if),
		.addr_pair_o(pair), .cmd_stb_o(stb), .cmd_code_o(code), .diff_mode_o(diff),
		.screen_off_o(soff), .key_light_o(light), .prox_en_o(prox));
	tpi_port_props i_props (.clk_i(clk_i), .nrst_i(nrst_i), .scl(i_tpi_link_if.scl),
		.sda(i_tpi_link_if.sda), .h_scl_oe(i_tpi_link_if.h_scl_oe),
		.h_sda_oe(i_tpi_link_if.h_sda_oe), .d_sda_oe(i_tpi_link_if.d_sda_oe),
		.h_int_oe(i_tpi_link_if.h_int_oe), .rst_n(i_tpi_link_if.rst_n));
	initial
		forever #2 clk_i = ~clk_i;
	// ****
	// bus and checks
	// ****
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		q = hrdata;
	endtask : ahb
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wait_st(input int b, input logic v);
		do
			ahb(1'b0, 8'h14, 32'h0, r);
		while (r[b] !== v);
	endtask : wait_st
	task setup(input logic [15:0] a, input logic [1:0] n, input logic [31:0] d);
		ahb(1'b1, 8'h04, {16'h0, a}, r);
		ahb(1'b1, 8'h08, {30'h0, n}, r);
		ahb(1'b1, 8'h0c, d, r);
	endtask : setup
	// waiting for busy first avoids reading a stale idle
	task xfer(input logic [31:0] ctl);
		ahb(1'b1, 8'h00, ctl, r);
		wait_st(0, 1'b1);
		wait_st(0, 1'b0);
	endtask : xfer
	// ****
	// scenarios
	// ****
	task t_init;
		ahb(1'b1, 8'h00, 32'h100, r);
		wait_st(2, 1'b1);
		chk("pair", 32'h0, {31'h0, pair});
		ahb(1'b0, 8'h18, 32'h0, r);
		chk("unmapped", 32'h0, r);
		chk("hresp", 32'h0, {31'h0, hresp});
		$display("t_init done");
	endtask : t_init
	task t_write;
		setup(16'h8040, 2'h3, 32'hc35a3c01);
		xfer(32'h5);
		chk("nack", 32'h0, r & 32'h2);
		chk("strobes", 32'h1, stb_count);
		chk("code", {24'h0, TPI_CMD_DIFF}, {24'h0, code});
		chk("diff", 32'h1, {31'h0, diff});
		chk("light", 32'h3c, {24'h0, light});
		chk("prox", 32'h5a, {24'h0, prox});
		$display("t_write done");
	endtask : t_write
	// write-only byte reads as zero, the stored byte after it follows
	task t_read;
		setup(16'h8042, 2'h1, 32'h0);
		xfer(32'h7);
		chk("nack", 32'h0, r & 32'h2);
		ahb(1'b0, 8'h10, 32'h0, r);
		chk("rdata", 32'hc300, r & 32'hffff);
		$display("t_read done");
	endtask : t_read
	// other pair address: panel must stay silent
	task t_miss;
		setup(16'h8040, 2'h0, 32'h5);
		xfer(32'h205);
		chk("nack", 32'h2, r & 32'h2);
		chk("soff", 32'h0, {31'h0, soff});
		chk("strobes", 32'h1, stb_count);
		$display("t_miss done");
	endtask : t_miss
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	always @(posedge clk_i)
	begin
		cyc++;
		if (stb === 1'b1)
			stb_count++;
		if (cyc == 95000)
		begin
			bad_count++;
			finish_test;
		end
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		t_init;
		t_write;
		t_read;
		t_miss;
		finish_test;
	end
endmodule : tpi_port_test
`default_nettype wire
